// ### rtl/bridge_memory_window_regs.sv
// Overview of operation
// - memory floor field bits 15:4, read/write
// - memory floor low twenty bits are zero
// - memory ceiling field bits 31:20, read/write
// - memory ceiling low twenty bits are ones
// - windows use one-megabyte alignment and granularity
// - memory window decides memory-mapped I/O forwarding
// - memory floor half resets to zero
// - memory ceiling half resets to zero
// - prefetch floor register resets to one
// - prefetch floor twelve writable bits 15:4
// - prefetch floor bits 3:0 read one
// - prefetch floor upper half from separate register
// - prefetch floor decides memory forwarding
// - prefetch ceiling bits 31:20, low bits ones
`timescale 1ns/1ps
`default_nettype none

module bridge_memory_window_regs
  import mem_window_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // configuration access from the primary bus
  input  wire logic        cfg_valid,
  input  wire logic [3:0]  cfg_cmd,
  input  wire logic [7:0]  cfg_offset,
  input  wire logic [3:0]  primary_byte_lane_enables_b,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rvalid,
  // transaction address to classify
  input  wire logic [63:0] txn_addr,
  input  wire logic        txn_is_64,
  // forwarding decisions
  output logic             mem_window_hit,
  output logic             prefetch_window_hit,
  // expanded bounds for the forwarding logic
  output logic [31:0]      mem_window_floor,
  output logic [31:0]      mem_window_ceiling,
  output logic [63:0]      prefetch_window_floor,
  output logic [63:0]      prefetch_window_ceiling
);
  import mem_window_pkg::*;

  logic [BOUND_W-1:0] mem_floor_r,   mem_floor_nxt;
  logic [BOUND_W-1:0] mem_ceil_r,    mem_ceil_nxt;
  logic [BOUND_W-1:0] pref_floor_r,  pref_floor_nxt;
  logic [BOUND_W-1:0] pref_ceil_r,   pref_ceil_nxt;
  logic [31:0]        pref_lo_up_r,  pref_lo_up_nxt;
  logic [31:0]        pref_hi_up_r,  pref_hi_up_nxt;
  logic [31:0]        rdata_nxt;
  logic               rvalid_nxt;
  logic               wr_en;
  logic               rd_en;
  logic [3:0]         be;
  logic [15:0]        mem_floor_reg;
  logic [15:0]        mem_window_ceiling_reg;
  logic [15:0]        prefetch_window_floor_reg;
  logic [15:0]        pref_ceil_half;
  logic [31:0]        floor_ext_nxt;
  logic [31:0]        ceil_ext_nxt;
  logic [63:0]        pfloor_ext_nxt;
  logic [63:0]        pceil_ext_nxt;
  logic               mem_hit_nxt;
  logic               pref_hit_nxt;

  // decode strobes; byte enables are active low on the primary bus
  assign wr_en = cfg_valid && (cfg_cmd == CMD_CFG_WRITE);
  assign rd_en = cfg_valid && (cfg_cmd == CMD_CFG_READ);
  assign be    = ~primary_byte_lane_enables_b;

  // register images as software reads them
  // reserved read zero
  assign mem_floor_reg             = {mem_floor_r, 4'h0};
  assign mem_window_ceiling_reg    = {mem_ceil_r, 4'h0};
  assign prefetch_window_floor_reg = {pref_floor_r, ADDR64_CAP};
  assign pref_ceil_half            = {pref_ceil_r, ADDR64_CAP};

  // next state of the writable bound fields, per byte lane
  always_comb begin
    mem_floor_nxt  = mem_floor_r;
    mem_ceil_nxt   = mem_ceil_r;
    pref_floor_nxt = pref_floor_r;
    pref_ceil_nxt  = pref_ceil_r;
    pref_lo_up_nxt = pref_lo_up_r;
    pref_hi_up_nxt = pref_hi_up_r;
    if (wr_en) begin
      case (cfg_offset)
        WIN_MEM_OFFSET: begin
          if (be[0]) mem_floor_nxt[3:0]  = cfg_wdata[7:4];
          if (be[1]) mem_floor_nxt[11:4] = cfg_wdata[15:8];
          if (be[2]) mem_ceil_nxt[3:0]   = cfg_wdata[23:20];
          if (be[3]) mem_ceil_nxt[11:4]  = cfg_wdata[31:24];
        end
        WIN_PREF_OFFSET: begin
          if (be[0]) pref_floor_nxt[3:0]  = cfg_wdata[7:4];
          if (be[1]) pref_floor_nxt[11:4] = cfg_wdata[15:8];
          if (be[2]) pref_ceil_nxt[3:0]   = cfg_wdata[23:20];
          if (be[3]) pref_ceil_nxt[11:4]  = cfg_wdata[31:24];
        end
        WIN_PREF_LO_OFFSET: begin
          for (int i = 0; i < 4; i++) begin
            if (be[i]) pref_lo_up_nxt[i*8 +: 8] = cfg_wdata[i*8 +: 8];
          end
        end
        WIN_PREF_HI_OFFSET: begin
          for (int i = 0; i < 4; i++) begin
            if (be[i]) pref_hi_up_nxt[i*8 +: 8] = cfg_wdata[i*8 +: 8];
          end
        end
        default: begin
          mem_floor_nxt = mem_floor_r; // unmapped: write ignored
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_floor_r  <= MEM_FLOOR_RST[15:4];
      mem_ceil_r   <= MEM_CEIL_RST[15:4];
      pref_floor_r <= PREF_FLOOR_RST[15:4];
      pref_ceil_r  <= PREF_CEIL_RST[15:4];
      pref_lo_up_r <= PREF_UPPER_RST;
      pref_hi_up_r <= PREF_UPPER_RST;
    end else begin
      mem_floor_r  <= mem_floor_nxt;
      mem_ceil_r   <= mem_ceil_nxt;
      pref_floor_r <= pref_floor_nxt;
      pref_ceil_r  <= pref_ceil_nxt;
      pref_lo_up_r <= pref_lo_up_nxt;
      pref_hi_up_r <= pref_hi_up_nxt;
    end
  end

  // read mux; unmapped offsets read zero so probing never hangs
  always_comb begin
    rvalid_nxt = rd_en;
    rdata_nxt  = 32'h0000_0000;
    if (rd_en) begin
      case (cfg_offset)
        WIN_MEM_OFFSET:     rdata_nxt = {mem_window_ceiling_reg, mem_floor_reg};
        WIN_PREF_OFFSET:    rdata_nxt = {pref_ceil_half, prefetch_window_floor_reg};
        WIN_PREF_LO_OFFSET: rdata_nxt = pref_lo_up_r;
        WIN_PREF_HI_OFFSET: rdata_nxt = pref_hi_up_r;
        default:            rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // bound expansion and window compare, from the next-state fields
  // (decision and bounds register on the same edge that takes a write)
  always_comb begin
    floor_ext_nxt  = {mem_floor_nxt, FLOOR_FILL};
    ceil_ext_nxt   = {mem_ceil_nxt, CEIL_FILL};
    pfloor_ext_nxt = {pref_lo_up_nxt, pref_floor_nxt, FLOOR_FILL};
    pceil_ext_nxt  = {pref_hi_up_nxt, pref_ceil_nxt, CEIL_FILL};
    mem_hit_nxt    = !txn_is_64 && (txn_addr[31:0] >= floor_ext_nxt)
                     && (txn_addr[31:0] <= ceil_ext_nxt);
    pref_hit_nxt   = (txn_addr >= pfloor_ext_nxt) && (txn_addr <= pceil_ext_nxt);
  end

  // all outputs registered
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata               <= 32'h0000_0000;
      cfg_rvalid              <= 1'b0;
      mem_window_hit          <= 1'b0;
      prefetch_window_hit     <= 1'b0;
      mem_window_floor        <= 32'h0000_0000;
      mem_window_ceiling      <= 32'h000F_FFFF;
      prefetch_window_floor   <= 64'h0000_0000_0000_0000;
      prefetch_window_ceiling <= 64'h0000_0000_000F_FFFF;
    end else begin
      cfg_rdata               <= rdata_nxt;
      cfg_rvalid              <= rvalid_nxt;
      mem_window_hit          <= mem_hit_nxt;
      prefetch_window_hit     <= pref_hit_nxt;
      mem_window_floor        <= floor_ext_nxt;
      mem_window_ceiling      <= ceil_ext_nxt;
      prefetch_window_floor   <= pfloor_ext_nxt;
      prefetch_window_ceiling <= pceil_ext_nxt;
    end
  end

endmodule

`default_nettype wire

// ### rtl/mem_window_pkg.sv
package mem_window_pkg;

  // dword offsets of the configuration words holding the window bounds
  localparam logic [7:0] WIN_MEM_OFFSET      = 8'h20;
  localparam logic [7:0] WIN_PREF_OFFSET     = 8'h24;
  localparam logic [7:0] WIN_PREF_LO_OFFSET  = 8'h28;
  localparam logic [7:0] WIN_PREF_HI_OFFSET  = 8'h2C;

  // field layout: bound field in bits 15:4 of each 16-bit half
  localparam int BOUND_LSB   = 4;
  localparam int BOUND_W     = 12;
  localparam int GRAN_BITS   = 20;

  // reset values
  localparam logic [15:0] MEM_FLOOR_RST   = 16'h0000;
  localparam logic [15:0] MEM_CEIL_RST    = 16'h0000;
  localparam logic [15:0] PREF_FLOOR_RST  = 16'h0001;
  localparam logic [15:0] PREF_CEIL_RST   = 16'h0001;
  localparam logic [31:0] PREF_UPPER_RST  = 32'h0000_0000;
  localparam logic [3:0]  ADDR64_CAP      = 4'h1;

  // bus command codes for configuration cycles
  localparam logic [3:0] CMD_CFG_READ  = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hB;

  // lower-bit fill for the two ends of a window
  localparam logic [19:0] FLOOR_FILL = 20'h0_0000;
  localparam logic [19:0] CEIL_FILL  = 20'hF_FFFF;

endpackage

// ### testbench/bridge_memory_window_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_memory_window_regs_assertions (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // configuration access
  input  wire logic        cfg_valid,
  input  wire logic [3:0]  cfg_cmd,
  input  wire logic [7:0]  cfg_offset,
  input  wire logic [3:0]  primary_byte_lane_enables_b,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rvalid,
  // classification
  input  wire logic [63:0] txn_addr,
  input  wire logic        txn_is_64,
  input  wire logic        mem_window_hit,
  input  wire logic        prefetch_window_hit,
  input  wire logic [31:0] mem_window_floor,
  input  wire logic [31:0] mem_window_ceiling,
  input  wire logic [63:0] prefetch_window_ceiling
);
  import mem_window_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic rd, wr, ok_r;
  // decoded requests
  assign rd = cfg_valid && cfg_cmd == CMD_CFG_READ;
  assign wr = cfg_valid && cfg_cmd == CMD_CFG_WRITE && cfg_offset == WIN_MEM_OFFSET;
  // one edge after release, so past values never reach into reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ok_r <= 1'b0;
    end else begin
      ok_r <= 1'b1;
    end
  end
  AST_RVALID: assert property (rd |=> cfg_rvalid) else $error("read not answered");
  AST_NO_RVALID: assert property (!rd |=> !cfg_rvalid) else $error("stray read answer");
  AST_RDATA_IDLE: assert property (!cfg_rvalid |-> cfg_rdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  AST_FLOOR_LOW: assert property (mem_window_floor[19:0] == FLOOR_FILL)
    else $error("floor low bits not zero");
  AST_CEIL_LOW: assert property (mem_window_ceiling[19:0] == CEIL_FILL)
    else $error("ceiling low bits not ones");
  AST_PREF_CEIL_LOW: assert property (prefetch_window_ceiling[19:0] == CEIL_FILL)
    else $error("prefetch ceiling low bits not ones");
  AST_FLOOR_WR: assert property (wr && primary_byte_lane_enables_b[1:0] == 2'b00
    |=> mem_window_floor[31:20] == $past(cfg_wdata[15:4])) else $error("floor write lost");
  AST_CEIL_WR: assert property (wr && primary_byte_lane_enables_b[3:2] == 2'b00
    |=> mem_window_ceiling[31:20] == $past(cfg_wdata[31:20])) else $error("ceiling write lost");
  AST_MEM_HIT: assert property (ok_r && !$past(txn_is_64) |-> mem_window_hit ==
    ($past(txn_addr[31:0]) >= mem_window_floor && $past(txn_addr[31:0]) <= mem_window_ceiling))
    else $error("memory window decision wrong");
  AST_MEM_64: assert property (ok_r && $past(txn_is_64) |-> !mem_window_hit)
    else $error("memory window hit on wide address");
  // main scenarios
  cover property (rd ##1 cfg_rvalid);
  cover property (wr);
  cover property (mem_window_hit);
  cover property (prefetch_window_hit);
endmodule
bind bridge_memory_window_regs bridge_memory_window_regs_assertions i_assertions (.*);
`default_nettype wire

// ### testbench/bridge_memory_window_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module bridge_memory_window_regs_test;
  import mem_window_pkg::*;
  logic sys_clk, rst_b, cfg_valid, cfg_rvalid, txn_is_64, mem_window_hit, prefetch_window_hit;
  logic [3:0] cfg_cmd, primary_byte_lane_enables_b;
  logic [7:0] cfg_offset;
  logic [31:0] cfg_wdata, cfg_rdata, mem_window_floor, mem_window_ceiling;
  logic [63:0] txn_addr, prefetch_window_floor, prefetch_window_ceiling;
  int errors, compares;
  bridge_memory_window_regs i_bridge_memory_window_regs (.*);
  cfg_master i_cfg_master (.*);
  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
    i_cfg_master.acc(CMD_CFG_WRITE, o, b, d);
  endtask
  // answer is registered at the taking edge and checked just after it
  task automatic rd(input logic [7:0] o, input logic [31:0] e);
    i_cfg_master.acc(CMD_CFG_READ, o, 4'h0, 32'h0000_0000);
    #1;
    `CHK(cfg_rvalid, 1'b1)
    `CHK(cfg_rdata, e)
  endtask
  // decision is registered, so look one edge after the address lands
  task automatic hit(input logic [63:0] a, input logic w, input logic em, input logic ep);
    @(posedge sys_clk);
    txn_addr <= a;
    txn_is_64 <= w;
    @(posedge sys_clk);
    #1;
    `CHK(mem_window_hit, em)
    `CHK(prefetch_window_hit, ep)
  endtask
  task automatic t_reset();
    rd(WIN_MEM_OFFSET, 32'h0000_0000);
    rd(WIN_PREF_OFFSET, 32'h0001_0001);
    rd(WIN_PREF_LO_OFFSET, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000);
    `CHK(mem_window_ceiling, 32'h000F_FFFF)
  endtask
  task automatic t_mem();
    wr(WIN_MEM_OFFSET, 4'h0, 32'hFFFF_FFFF);
    rd(WIN_MEM_OFFSET, 32'hFFF0_FFF0);
    wr(WIN_MEM_OFFSET, 4'hC, 32'h0000_1000);
    rd(WIN_MEM_OFFSET, 32'hFFF0_1000);
    wr(WIN_MEM_OFFSET, 4'h3, 32'h1230_0000);
    rd(WIN_MEM_OFFSET, 32'h1230_1000);
    `CHK(mem_window_floor, 32'h1000_0000)
    `CHK(mem_window_ceiling, 32'h123F_FFFF)
    hit(64'h0000_0000_1000_0000, 1'b0, 1'b1, 1'b0);
    hit(64'h0000_0000_0FFF_FFFF, 1'b0, 1'b0, 1'b0);
    hit(64'h0000_0000_123F_FFFF, 1'b0, 1'b1, 1'b0);
    hit(64'h0000_0000_1240_0000, 1'b0, 1'b0, 1'b0);
    hit(64'h0000_0001_1000_0000, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_pref();
    wr(WIN_PREF_OFFSET, 4'h0, 32'hFFFF_FFFF);
    rd(WIN_PREF_OFFSET, 32'hFFF1_FFF1);
    wr(WIN_PREF_LO_OFFSET, 4'h0, 32'h0000_0001);
    wr(WIN_PREF_HI_OFFSET, 4'h0, 32'h0000_0001);
    wr(WIN_PREF_OFFSET, 4'h0, 32'h2000_1000);
    wr(8'h30, 4'h0, 32'hFFFF_FFFF);
    rd(WIN_PREF_OFFSET, 32'h2001_1001);
    `CHK(prefetch_window_floor, 64'h0000_0001_1000_0000)
    `CHK(prefetch_window_ceiling, 64'h0000_0001_200F_FFFF)
    hit(64'h0000_0001_1000_0000, 1'b1, 1'b0, 1'b1);
    hit(64'h0000_0000_1000_0000, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic end_sim();
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // reset for six cycles, then the scenarios in turn
  initial begin
    {errors, compares} = '0;
    {rst_b, txn_is_64, txn_addr} = '0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_mem();
    t_pref();
    end_sim();
  end
endmodule
`default_nettype wire

// ### testbench/cfg_master.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_master (
  // bus clock
  input  wire logic        sys_clk,
  // configuration request
  output logic             cfg_valid,
  output logic [3:0]       cfg_cmd,
  output logic [7:0]       cfg_offset,
  output logic [3:0]       primary_byte_lane_enables_b,
  output logic [31:0]      cfg_wdata
);
  import mem_window_pkg::*;
  // idle bus at time zero
  initial begin
    {cfg_valid, cfg_cmd, cfg_offset, primary_byte_lane_enables_b, cfg_wdata} = '0;
  end
  // request stands for the taking edge; released offset and data lines flip so stale data cannot pass
  task automatic acc(input logic [3:0] c, input logic [7:0] o, input logic [3:0] b,
                     input logic [31:0] d);
    @(posedge sys_clk);
    cfg_valid <= 1'b1;
    cfg_cmd <= c;
    cfg_offset <= o;
    primary_byte_lane_enables_b <= b;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_valid <= 1'b0;
    cfg_offset <= ~o;
    cfg_wdata <= ~d;
  endtask
endmodule
`default_nettype wire
